// File: xcvr_regs_pkg.sv
// Register map, field positions and timing constants for the transceiver register bank
package xcvr_regs_pkg;
  localparam logic [7:0] CAN_CTRL_ADDR = 8'h20;
  localparam logic [7:0] LIN_CTRL_ADDR = 8'h21;
  localparam logic [7:0] XCVR_STAT_ADDR = 8'h22;
  localparam logic [7:0] CAN_CTRL_RESET = 8'h00;
  localparam logic [7:0] LIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] CAN_CTRL_WMASK_PN = 8'h7F;
  localparam logic [7:0] CAN_CTRL_WMASK_NOPN = 8'h0F;
  localparam int LIN_TWO_SLOPE_POS = 6;
  localparam int LIN_TWO_MODE_POS = 4;
  localparam int LIN_ONE_SLOPE_POS = 2;
  localparam int LIN_ONE_MODE_POS = 0;
  localparam int CAN_MODE_POS = 0;
  localparam int CFG_VALID_POS = 5;
  localparam logic [1:0] MODE_OFFLINE = 2'h0;
  localparam logic [1:0] MODE_ACTIVE_A = 2'h1;
  localparam logic [1:0] MODE_ACTIVE_B = 2'h2;
  localparam logic [1:0] MODE_LISTEN = 2'h3;
  localparam logic [1:0] SLOPE_NO_TIMEOUT = 2'h2;
  localparam int STAT_TX_READY = 7;
  localparam int STAT_PN_ERR = 6;
  localparam int STAT_PN_CFG = 5;
  localparam int STAT_OSC = 4;
  localparam int STAT_SILENT = 3;
  localparam int STAT_LIN_LOW = 2;
  localparam int STAT_CAN_LOW = 1;
  localparam int STAT_CAN_TO = 0;
  localparam int CLK_HZ = 20_000_000;
  localparam int LIN_TIMEOUT_US = 20_000;
  localparam int LIN_TIMEOUT_CYCLES = (LIN_TIMEOUT_US / 1000) * (CLK_HZ / 1000);
  localparam int SILENCE_US = 1_000_000;
  localparam int SILENCE_CYCLES = (SILENCE_US / 1000) * (CLK_HZ / 1000);
endpackage

// File: xcvr_regs.sv
// Transceiver control and status register bank with LIN time-out and CAN silence logic
`timescale 1ns/1ps
module xcvr_regs #(
  parameter int LIN_CHANNELS = 2,
  parameter bit HAS_PN = 1'b1,
  parameter int LIN_TIMEOUT = xcvr_regs_pkg::LIN_TIMEOUT_CYCLES,
  parameter int SILENCE_TIME = xcvr_regs_pkg::SILENCE_CYCLES
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic normal_mode_i,
  input wire logic can_tx_enabled_i,
  input wire logic fd_frame_error_flag_i,
  input wire logic wake_osc_locked_i,
  input wire logic can_bus_active_i,
  input wire logic lin_undervolt_i,
  input wire logic can_supply_rail_low_i,
  input wire logic can_tx_timeout_i,
  input wire logic [1:0] lin_transmit_input_i,
  output logic [1:0] lin_tx_enable_o,
  output logic [1:0] lin_rx_enable_o,
  output logic [1:0] lin_tx_data_o,
  output logic [1:0] can_mode_sel_o,
  output logic can_uv_detect_en_o
);
  typedef struct packed {
    logic [7:0] can_ctrl;
    logic [7:0] lin_ctrl;
    logic [7:0] rdata;
    logic [1:0] tx_s1;
    logic [1:0] tx_s2;
    logic [1:0] tx_prev;
    logic [1:0] to_hit;
    logic [1:0][31:0] to_cnt;
    logic [31:0] sil_cnt;
    logic [6:0] in_s1;
    logic [6:0] in_s2;
    logic [1:0] tx_en;
    logic [1:0] rx_en;
    logic [1:0] tx_data;
    logic lin_off_uv;
    logic [1:0] can_mode;
    logic can_uv;
  } state_s;
  state_s st_reg;
  state_s st_next;
  logic [7:0] status;
  logic [1:0] lin_mode [2];
  logic [1:0] lin_slope [2];

  // ----------------------------------------------------------------
  // Field decoding
  // ----------------------------------------------------------------
  function automatic logic mode_is_active(input logic [1:0] m);
    return (m == xcvr_regs_pkg::MODE_ACTIVE_A) || (m == xcvr_regs_pkg::MODE_ACTIVE_B);
  endfunction

  // CAN supply monitoring only runs in modes 01 and 11
  function automatic logic can_uv_active(input logic [1:0] m);
    return (m == xcvr_regs_pkg::MODE_ACTIVE_A) || (m == xcvr_regs_pkg::MODE_LISTEN);
  endfunction

  assign lin_mode[0] = st_reg.lin_ctrl[xcvr_regs_pkg::LIN_ONE_MODE_POS +: 2];
  assign lin_mode[1] = st_reg.lin_ctrl[xcvr_regs_pkg::LIN_TWO_MODE_POS +: 2];
  assign lin_slope[0] = st_reg.lin_ctrl[xcvr_regs_pkg::LIN_ONE_SLOPE_POS +: 2];
  assign lin_slope[1] = st_reg.lin_ctrl[xcvr_regs_pkg::LIN_TWO_SLOPE_POS +: 2];

  // ----------------------------------------------------------------
  // Status composition
  // ----------------------------------------------------------------
  always_comb
  begin
    logic cfg_ok;
    logic [1:0] cm;
    cfg_ok = st_reg.can_ctrl[xcvr_regs_pkg::CFG_VALID_POS];
    cm = st_reg.can_ctrl[xcvr_regs_pkg::CAN_MODE_POS +: 2];
    status = 8'h00;
    status[xcvr_regs_pkg::STAT_TX_READY] = st_reg.in_s2[0];
    if (HAS_PN)
    begin
      status[xcvr_regs_pkg::STAT_PN_ERR] = st_reg.in_s2[1] | ~cfg_ok;
      status[xcvr_regs_pkg::STAT_PN_CFG] = cfg_ok;
      status[xcvr_regs_pkg::STAT_OSC] = st_reg.in_s2[2];
    end
    status[xcvr_regs_pkg::STAT_SILENT] = (st_reg.sil_cnt >= 32'(SILENCE_TIME));
    status[xcvr_regs_pkg::STAT_LIN_LOW] = st_reg.lin_off_uv;
    status[xcvr_regs_pkg::STAT_CAN_LOW] = st_reg.in_s2[5] & normal_mode_i
      & can_uv_active(cm);
    status[xcvr_regs_pkg::STAT_CAN_TO] = st_reg.in_s2[6];
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] lin_wmask;
    st_next = st_reg;
    lin_wmask = (LIN_CHANNELS > 1) ? 8'hFF : 8'h0F;
    st_next.in_s1 = {can_tx_timeout_i, can_supply_rail_low_i, lin_undervolt_i,
      can_bus_active_i, wake_osc_locked_i, fd_frame_error_flag_i, can_tx_enabled_i};
    st_next.in_s2 = st_reg.in_s1;
    st_next.tx_s1 = lin_transmit_input_i;
    st_next.tx_s2 = st_reg.tx_s1;
    st_next.tx_prev = st_reg.tx_s2;
    st_next.can_mode = st_reg.can_ctrl[xcvr_regs_pkg::CAN_MODE_POS +: 2];
    st_next.can_uv = normal_mode_i
      && can_uv_active(st_reg.can_ctrl[xcvr_regs_pkg::CAN_MODE_POS +: 2]);
    if (wr_en_i)
    begin
      case (addr_i)
        xcvr_regs_pkg::CAN_CTRL_ADDR:
          st_next.can_ctrl = wdata_i & (HAS_PN ? xcvr_regs_pkg::CAN_CTRL_WMASK_PN
            : xcvr_regs_pkg::CAN_CTRL_WMASK_NOPN);
        xcvr_regs_pkg::LIN_CTRL_ADDR:
          st_next.lin_ctrl = wdata_i & lin_wmask;
        default:
          st_next.lin_ctrl = st_reg.lin_ctrl;
      endcase
    end
    if (rd_en_i)
    begin
      case (addr_i)
        xcvr_regs_pkg::CAN_CTRL_ADDR: st_next.rdata = st_reg.can_ctrl;
        xcvr_regs_pkg::LIN_CTRL_ADDR: st_next.rdata = st_reg.lin_ctrl;
        xcvr_regs_pkg::XCVR_STAT_ADDR: st_next.rdata = status;
        default: st_next.rdata = 8'h00;
      endcase
    end
    // Silence timer saturates at the threshold
    if (st_reg.in_s2[3])
      st_next.sil_cnt = 32'h0000_0000;
    else if (st_reg.sil_cnt < 32'(SILENCE_TIME))
      st_next.sil_cnt = st_reg.sil_cnt + 32'h0000_0001;
    // LIN undervoltage in Normal mode holds offline while supply is low; clears on recovery or outside Normal
    if (normal_mode_i && st_reg.in_s2[4])
      st_next.lin_off_uv = 1'b1;
    else
      st_next.lin_off_uv = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      if (st_reg.tx_s2[i] || lin_slope[i] == xcvr_regs_pkg::SLOPE_NO_TIMEOUT)
      begin
        st_next.to_cnt[i] = 32'h0000_0000;
        st_next.to_hit[i] = 1'b0;
      end
      else if (st_reg.tx_prev[i] && !st_reg.tx_s2[i])
        st_next.to_cnt[i] = 32'h0000_0001;
      else if (st_reg.to_cnt[i] >= 32'(LIN_TIMEOUT))
        st_next.to_hit[i] = 1'b1;
      else if (st_reg.to_cnt[i] != 32'h0000_0000)
        st_next.to_cnt[i] = st_reg.to_cnt[i] + 32'h0000_0001;
      st_next.rx_en[i] = 1'b0;
      st_next.tx_en[i] = 1'b0;
      if (i < LIN_CHANNELS && !st_reg.lin_off_uv)
      begin
        case (lin_mode[i])
          xcvr_regs_pkg::MODE_ACTIVE_A, xcvr_regs_pkg::MODE_ACTIVE_B:
          begin
            st_next.rx_en[i] = normal_mode_i;
            st_next.tx_en[i] = normal_mode_i && mode_is_active(lin_mode[i]);
          end
          xcvr_regs_pkg::MODE_LISTEN:
            st_next.rx_en[i] = 1'b1;
          default:
            st_next.rx_en[i] = 1'b0;
        endcase
      end
      // Bus forced recessive once time-out fires
      st_next.tx_data[i] = st_reg.tx_s2[i] | st_reg.to_hit[i] | ~st_next.tx_en[i];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      st_reg <= '0;
      st_reg.can_ctrl <= xcvr_regs_pkg::CAN_CTRL_RESET;
      st_reg.lin_ctrl <= xcvr_regs_pkg::LIN_CTRL_RESET;
      st_reg.tx_s1 <= 2'h3;
      st_reg.tx_s2 <= 2'h3;
      st_reg.tx_prev <= 2'h3;
      st_reg.tx_data <= 2'h3;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = st_reg.rdata;
  assign lin_tx_enable_o = st_reg.tx_en;
  assign lin_rx_enable_o = st_reg.rx_en;
  assign lin_tx_data_o = st_reg.tx_data;
  assign can_mode_sel_o = st_reg.can_mode;
  assign can_uv_detect_en_o = st_reg.can_uv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_listen_no_tx: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(lin_mode[0]) == xcvr_regs_pkg::MODE_LISTEN |-> !lin_tx_enable_o[0])
    else $error("Listen-only channel transmits");
  a_offline_quiet: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(lin_mode[0]) == xcvr_regs_pkg::MODE_OFFLINE |-> !lin_rx_enable_o[0])
    else $error("Offline channel receives");
  a_timeout_recessive: assert property (@(posedge clock_i) disable iff (srst_i)
    st_reg.to_hit[0] |=> lin_tx_data_o[0])
    else $error("Time-out did not force recessive");
  a_slope_notimeout: assert property (@(posedge clock_i) disable iff (srst_i)
    lin_slope[0] == xcvr_regs_pkg::SLOPE_NO_TIMEOUT |=> !st_reg.to_hit[0])
    else $error("Time-out fired while disabled");
  a_stat_ro: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_en_i && addr_i == xcvr_regs_pkg::XCVR_STAT_ADDR |=> $stable(st_reg.can_ctrl)
      && $stable(st_reg.lin_ctrl))
    else $error("Status write changed control");
  a_cfg_mirror: assert property (@(posedge clock_i) disable iff (srst_i)
    HAS_PN |-> status[xcvr_regs_pkg::STAT_PN_CFG] == st_reg.can_ctrl[5])
    else $error("Config status mismatch");
  a_pn_err: assert property (@(posedge clock_i) disable iff (srst_i)
    HAS_PN && !st_reg.can_ctrl[5] |-> status[xcvr_regs_pkg::STAT_PN_ERR])
    else $error("Config error not reported");
  a_can_low_gate: assert property (@(posedge clock_i) disable iff (srst_i)
    !normal_mode_i |-> !status[xcvr_regs_pkg::STAT_CAN_LOW])
    else $error("Supply low outside Normal");
  a_lin_low_gate: assert property (@(posedge clock_i) disable iff (srst_i)
    st_reg.lin_off_uv |=> !lin_tx_enable_o[0] && !lin_tx_enable_o[1])
    else $error("LIN active during undervoltage");
  a_listen_rx_on: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(lin_mode[0]) == xcvr_regs_pkg::MODE_LISTEN && !$past(st_reg.lin_off_uv)
      |-> lin_rx_enable_o[0])
    else $error("Listen-only channel deaf");
  a_listen_rx_two: assert property (@(posedge clock_i) disable iff (srst_i)
    (LIN_CHANNELS > 1) && $past(lin_mode[1]) == xcvr_regs_pkg::MODE_LISTEN
      && !$past(st_reg.lin_off_uv) |-> lin_rx_enable_o[1] && !lin_tx_enable_o[1])
    else $error("Second listen-only channel wrong");
  a_active_tx_one: assert property (@(posedge clock_i) disable iff (srst_i)
    mode_is_active($past(lin_mode[0])) && $past(normal_mode_i)
      && !$past(st_reg.lin_off_uv) |-> lin_tx_enable_o[0] && lin_rx_enable_o[0])
    else $error("Active channel one not enabled");
  a_active_tx_two: assert property (@(posedge clock_i) disable iff (srst_i)
    (LIN_CHANNELS > 1) && mode_is_active($past(lin_mode[1])) && $past(normal_mode_i)
      && !$past(st_reg.lin_off_uv) |-> lin_tx_enable_o[1] && lin_rx_enable_o[1])
    else $error("Active channel two not enabled");
  a_offline_two: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(lin_mode[1]) == xcvr_regs_pkg::MODE_OFFLINE
      |-> !lin_rx_enable_o[1] && !lin_tx_enable_o[1])
    else $error("Offline channel two enabled");
  a_no_tx_outside: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(normal_mode_i) |-> lin_tx_enable_o == 2'b00)
    else $error("LIN transmits outside Normal");
  a_tx_ready_stat: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(srst_i) && !$past(srst_i, 2)
      |-> status[xcvr_regs_pkg::STAT_TX_READY] == $past(can_tx_enabled_i, 2))
    else $error("Transmitter ready status wrong");
  a_osc_stat: assert property (@(posedge clock_i) disable iff (srst_i)
    HAS_PN && !$past(srst_i) && !$past(srst_i, 2)
      |-> status[xcvr_regs_pkg::STAT_OSC] == $past(wake_osc_locked_i, 2))
    else $error("Oscillator status wrong");
  a_can_to_stat: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(srst_i) && !$past(srst_i, 2)
      |-> status[xcvr_regs_pkg::STAT_CAN_TO] == $past(can_tx_timeout_i, 2))
    else $error("CAN failure status wrong");
  a_can_low_set: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(srst_i) && !$past(srst_i, 2) && normal_mode_i && st_reg.can_ctrl[0]
      && $past(can_supply_rail_low_i, 2) |-> status[xcvr_regs_pkg::STAT_CAN_LOW])
    else $error("CAN supply low not reported");
  a_silent_clear: assert property (@(posedge clock_i) disable iff (srst_i)
    st_reg.in_s2[3] |=> !status[xcvr_regs_pkg::STAT_SILENT])
    else $error("Silence reported while bus active");
  a_silent_set: assert property (@(posedge clock_i) disable iff (srst_i)
    st_reg.sil_cnt == 32'(SILENCE_TIME - 1) && !st_reg.in_s2[3]
      |=> status[xcvr_regs_pkg::STAT_SILENT])
    else $error("Silence not reported");
  a_uv_offline: assert property (@(posedge clock_i) disable iff (srst_i)
    normal_mode_i && st_reg.in_s2[4] |=> status[xcvr_regs_pkg::STAT_LIN_LOW])
    else $error("LIN undervoltage not reported");
  a_uv_not_normal: assert property (@(posedge clock_i) disable iff (srst_i)
    !normal_mode_i |=> !status[xcvr_regs_pkg::STAT_LIN_LOW])
    else $error("LIN undervoltage outside Normal");
  a_timeout_fires: assert property (@(posedge clock_i) disable iff (srst_i)
    st_reg.to_cnt[0] >= 32'(LIN_TIMEOUT) && !st_reg.tx_s2[0]
      && lin_slope[0] != xcvr_regs_pkg::SLOPE_NO_TIMEOUT |=> st_reg.to_hit[0])
    else $error("Dominant time-out missed");
  a_edge_clears: assert property (@(posedge clock_i) disable iff (srst_i)
    st_reg.tx_s2[0] |=> !st_reg.to_hit[0])
    else $error("Rising edge did not clear time-out");
  a_can_reserved: assert property (@(posedge clock_i) disable iff (srst_i)
    !st_reg.can_ctrl[7])
    else $error("Reserved CAN control bit set");
  a_mode_copy: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(srst_i) |-> can_mode_sel_o == $past(st_reg.can_ctrl[1:0]))
    else $error("CAN mode output wrong");
  a_uv_det_mode: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(srst_i) |-> can_uv_detect_en_o == ($past(normal_mode_i)
      && $past(st_reg.can_ctrl[0])))
    else $error("CAN undervoltage detect wrong");
  a_rdata_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    !rd_en_i |=> $stable(rdata_o))
    else $error("Read data changed without read");
endmodule

// File: host_model.sv
// Host model that reaches the register bank through its byte-wide strobe port
`timescale 1ns/1ps
module host_model #(
  parameter bit SINGLE_LIN = 1'b0
) (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Released address and data show the inverse of the last value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (SINGLE_LIN && a == xcvr_regs_pkg::LIN_CTRL_ADDR) ? (d & 8'h0F) : d;
    @(posedge clock_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clock_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// File: transceiver_ctrl_status_regs_test.sv
// Self-checking testbench for the transceiver register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end
module transceiver_ctrl_status_regs_test;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic normal_mode_i = 1'b0;
  logic [6:0] st = 7'h48;
  logic [1:0] lin_in = 2'h3;
  logic wr_en, rd_en;
  logic [7:0] addr, wdata, rdata_o, d;
  logic [1:0] lin_tx_enable_o, lin_rx_enable_o, lin_tx_data_o, can_mode_sel_o;
  logic can_uv_detect_en_o;
  logic [31:0] seed = 32'h91f6_c46d;
  int err_total = 0;
  int cmp_count = 0;
  always #25 clock_i = ~clock_i;
  xcvr_regs #(.LIN_TIMEOUT(20), .SILENCE_TIME(50)) xcvr_regs_inst (
    .clock_i(clock_i), .srst_i(srst_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata_o), .normal_mode_i(normal_mode_i),
    .can_tx_enabled_i(st[6]), .fd_frame_error_flag_i(st[5]), .wake_osc_locked_i(st[4]),
    .can_bus_active_i(st[3]), .lin_undervolt_i(st[2]), .can_supply_rail_low_i(st[1]),
    .can_tx_timeout_i(st[0]), .lin_transmit_input_i(lin_in),
    .lin_tx_enable_o(lin_tx_enable_o), .lin_rx_enable_o(lin_rx_enable_o),
    .lin_tx_data_o(lin_tx_data_o), .can_mode_sel_o(can_mode_sel_o),
    .can_uv_detect_en_o(can_uv_detect_en_o));
  host_model host_model_inst (.clock_i(clock_i), .rdata_i(rdata_o), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // Expected status with the bus held active
  function automatic logic [7:0] exp_stat(input logic [6:0] s, input logic [7:0] c,
    input logic nm);
    return {s[6], s[5] | ~c[5], c[5], s[4], 1'b0, s[2] & nm, s[1] & nm & c[0], s[0]};
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    host_model_inst.read_reg(8'h20, d);
    `CHK("can reset", 8'h00, d)
    host_model_inst.read_reg(8'h21, d);
    `CHK("lin reset", 8'h00, d)
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      host_model_inst.write_reg(8'h21, seed[7:0]);
      host_model_inst.read_reg(8'h21, d);
      `CHK("lin ctrl", seed[7:0], d)
      host_model_inst.write_reg(8'h20, seed[15:8]);
      host_model_inst.read_reg(8'h20, d);
      `CHK("can ctrl", seed[15:8] & 8'h7F, d)
    end
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      @(posedge clock_i);
      st <= {seed[6:4], 1'b1, seed[2:0]};
      normal_mode_i <= seed[7];
      host_model_inst.write_reg(8'h20, seed[15:8]);
      repeat (4) @(posedge clock_i);
      host_model_inst.read_reg(8'h22, d);
      `CHK("status", exp_stat(st, seed[15:8], normal_mode_i), d)
      host_model_inst.write_reg(8'h22, ~d);
      host_model_inst.read_reg(8'h22, d);
      `CHK("status wr", exp_stat(st, seed[15:8], normal_mode_i), d)
    end
    host_model_inst.read_reg(8'h23, d);
    `CHK("unmapped", 8'h00, d)
    @(posedge clock_i);
    st <= 7'h48;
    normal_mode_i <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      host_model_inst.write_reg(8'h21, {2'h0, i[1:0], 2'h0, i[1:0]});
      host_model_inst.write_reg(8'h20, {6'h00, i[1:0]});
      repeat (3) @(posedge clock_i);
      #1;
      `CHK("tx en", {2{i == 1 || i == 2}}, lin_tx_enable_o)
      `CHK("rx en", {2{i != 0}}, lin_rx_enable_o)
      `CHK("can mode", i[1:0], can_mode_sel_o)
      `CHK("uv det", i[0], can_uv_detect_en_o)
    end
    host_model_inst.write_reg(8'h21, 8'h11);
    @(posedge clock_i);
    lin_in <= 2'h2;
    repeat (8) @(posedge clock_i);
    #1;
    `CHK("lin drive", 2'h2, lin_tx_data_o)
    repeat (30) @(posedge clock_i);
    #1;
    `CHK("lin timeout", 2'h3, lin_tx_data_o)
    lin_in <= 2'h3;
    host_model_inst.write_reg(8'h21, 8'h19);
    lin_in <= 2'h2;
    repeat (40) @(posedge clock_i);
    #1;
    `CHK("no timeout", 2'h2, lin_tx_data_o)
    lin_in <= 2'h3;
    st <= 7'h40;
    repeat (10) @(posedge clock_i);
    host_model_inst.read_reg(8'h22, d);
    `CHK("not silent", 1'b0, d[3])
    repeat (60) @(posedge clock_i);
    host_model_inst.read_reg(8'h22, d);
    `CHK("silent", 1'b1, d[3])
    results();
  end
endmodule
